// ### logic/ibc_input_buffer.sv
`timescale 1ns/1ps
module ibc_input_buffer #(
   parameter int DEPTH = 1024
) (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic [7:0] bus_addr_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic [31:0] bus_wdata_i,
   output logic [31:0] bus_rdata_o,
   output logic bus_rvalid_o,
   input wire logic sample_valid_i,
   input wire logic [15:0] sample_data_i,
   output logic sample_ready_o,
   input wire logic autocal_done_i,
   input wire logic scan_start_i,
   input wire logic scan_done_i,
   input wire logic [2:0] input_function_select_i,
   output logic scan_abort_o,
   output logic mode_diff_o,
   output logic mode_se_o,
   output logic ref_ground_o,
   output logic ref_vref_o,
   output logic irq_o
);
   // Pointer width; power-of-two depth lets pointers wrap freely
   localparam int AW = $clog2(DEPTH);
   localparam logic [15:0] DEPTH_C = 16'(DEPTH);

   // Count must fit the 16-bit fill field
   if (DEPTH < 2 || DEPTH > 32768 || (1 << AW) != DEPTH) begin : g_chk
      $error("DEPTH must be a power of two, 2 to 32768");
   end

   // Address match on a bus strobe
   function automatic logic hit(input logic s, input logic [7:0] a,
                                input logic [7:0] off);
      return s && (a == off);
   endfunction : hit

   // Sample storage
   logic [15:0] mem [DEPTH];
   // Buffer state
   logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
   logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
   logic [15:0] count_reg, count_next;
   logic [15:0] thr_reg, thr_next;
   ibc_pkg::ibc_clr_type clr_reg, clr_next;
   // Threshold flag, last cycle's copy for edges
   logic tflag, tflag_d_reg, tflag_d_next;
   // Interrupt control fields
   logic [2:0] g0_sel_reg, g0_sel_next;
   logic [2:0] g1_sel_reg, g1_sel_next;
   logic g0_req_reg, g0_req_next;
   logic g1_req_reg, g1_req_next;
   // Function decode outputs
   logic [3:0] mode_reg, mode_next;
   // Read answer
   logic [31:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   // Cycle strobes
   logic push, pop, clr_start, g0_ev, g1_ev;
   logic wr_irq, wr_bctl;

   // Accept samples only while idle and not full
   assign sample_ready_o = (clr_reg == ibc_pkg::CLR_IDLE) &&
                           (count_reg != DEPTH_C);

   // Next-state logic for the whole block
   always_comb begin
      wr_irq = hit(bus_wr_i, bus_addr_i, ibc_pkg::OFF_IRQ_CTL);
      wr_bctl = hit(bus_wr_i, bus_addr_i, ibc_pkg::OFF_BUF_CTL);
      push = sample_valid_i && sample_ready_o;
      // Empty buffer reads do not pop
      pop = hit(bus_rd_i, bus_addr_i, ibc_pkg::OFF_DATA) &&
            (count_reg != 16'h0000) && (clr_reg == ibc_pkg::CLR_IDLE);
      tflag = count_reg > thr_reg;
      // Clear is only started from idle
      clr_start = wr_bctl && bus_wdata_i[ibc_pkg::CLR_BIT] &&
                  (clr_reg == ibc_pkg::CLR_IDLE);
      thr_next = thr_reg;
      if (wr_bctl) begin
         thr_next = bus_wdata_i[ibc_pkg::THR_LSB +: 16];
      end
      // Clear sequencer: one busy cycle, then back to idle
      unique case (clr_reg)
         ibc_pkg::CLR_IDLE: begin
            clr_next = clr_start ? ibc_pkg::CLR_BUSY : ibc_pkg::CLR_IDLE;
         end
         ibc_pkg::CLR_BUSY: begin
            clr_next = ibc_pkg::CLR_IDLE;
         end
      endcase
      // Pointers and count
      if (clr_reg == ibc_pkg::CLR_BUSY) begin
         wr_ptr_next = '0;
         rd_ptr_next = '0;
         count_next = 16'h0000;
      end else begin
         wr_ptr_next = wr_ptr_reg + AW'(push);
         rd_ptr_next = rd_ptr_reg + AW'(pop);
         count_next = count_reg + {15'h0000, push} - {15'h0000, pop};
      end
      tflag_d_next = tflag;
      // Group 0 condition; reserved codes raise nothing
      case (g0_sel_reg)
         ibc_pkg::G0_IDLE: g0_ev = 1'b0;
         ibc_pkg::G0_AUTOCAL: g0_ev = autocal_done_i;
         ibc_pkg::G0_SCAN_START: g0_ev = scan_start_i;
         ibc_pkg::G0_SCAN_DONE: g0_ev = scan_done_i;
         default: g0_ev = 1'b0;
      endcase
      // Group 1 condition on threshold flag edges
      case (g1_sel_reg)
         ibc_pkg::G1_NONE: g1_ev = 1'b0;
         ibc_pkg::G1_RISE: g1_ev = tflag && !tflag_d_reg;
         ibc_pkg::G1_FALL: g1_ev = !tflag && tflag_d_reg;
         default: g1_ev = 1'b0;
      endcase
      // Only the eight active bits are stored
      g0_sel_next = g0_sel_reg;
      g1_sel_next = g1_sel_reg;
      g0_req_next = g0_req_reg;
      g1_req_next = g1_req_reg;
      if (wr_irq) begin
         g0_sel_next = bus_wdata_i[ibc_pkg::G0_SEL_LSB +: 3];
         g1_sel_next = bus_wdata_i[ibc_pkg::G1_SEL_LSB +: 3];
         g0_req_next = bus_wdata_i[ibc_pkg::G0_REQ_BIT];
         g1_req_next = bus_wdata_i[ibc_pkg::G1_REQ_BIT];
      end
      // An event in the clearing cycle wins over the clear
      g0_req_next = g0_req_next | g0_ev;
      g1_req_next = g1_req_next | g1_ev;
      // Function select decode; reserved codes select nothing
      mode_next = 4'h0;
      unique case (input_function_select_i)
         ibc_pkg::FN_DIFF: mode_next[0] = 1'b1;
         ibc_pkg::FN_SE: mode_next[1] = 1'b1;
         ibc_pkg::FN_ZERO: mode_next[2] = 1'b1;
         ibc_pkg::FN_VREF: mode_next[3] = 1'b1;
         default: mode_next = 4'h0;
      endcase
      // Read multiplexer; unmapped offsets answer zero
      rvalid_next = bus_rd_i;
      rdata_next = 32'h0000_0000;
      if (bus_rd_i) begin
         unique case (bus_addr_i)
            ibc_pkg::OFF_IRQ_CTL: begin
               rdata_next[ibc_pkg::G0_SEL_LSB +: 3] = g0_sel_reg;
               rdata_next[ibc_pkg::G0_REQ_BIT] = g0_req_reg;
               rdata_next[ibc_pkg::G1_SEL_LSB +: 3] = g1_sel_reg;
               rdata_next[ibc_pkg::G1_REQ_BIT] = g1_req_reg;
            end
            ibc_pkg::OFF_DATA: begin
               if (pop) begin
                  rdata_next[15:0] = mem[rd_ptr_reg];
               end
            end
            ibc_pkg::OFF_BUF_CTL: begin
               rdata_next[ibc_pkg::THR_LSB +: 16] = thr_reg;
               rdata_next[ibc_pkg::CLR_BIT] =
                  (clr_reg == ibc_pkg::CLR_BUSY);
               rdata_next[ibc_pkg::TFLAG_BIT] = tflag;
            end
            ibc_pkg::OFF_FILL: rdata_next[15:0] = count_reg;
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // Registers; sample storage itself needs no reset
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= 16'h0000;
         thr_reg <= ibc_pkg::THR_RST;
         clr_reg <= ibc_pkg::CLR_IDLE;
         tflag_d_reg <= 1'b0;
         g0_sel_reg <= ibc_pkg::G0_SEL_RST;
         g1_sel_reg <= ibc_pkg::G1_SEL_RST;
         g0_req_reg <= ibc_pkg::G0_REQ_RST;
         g1_req_reg <= ibc_pkg::G1_REQ_RST;
         mode_reg <= 4'h0;
         rdata_reg <= 32'h0000_0000;
         rvalid_reg <= 1'b0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
         thr_reg <= thr_next;
         clr_reg <= clr_next;
         tflag_d_reg <= tflag_d_next;
         g0_sel_reg <= g0_sel_next;
         g1_sel_reg <= g1_sel_next;
         g0_req_reg <= g0_req_next;
         g1_req_reg <= g1_req_next;
         mode_reg <= mode_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
      if (push) begin
         mem[wr_ptr_reg] <= sample_data_i;
      end
   end

   // Outputs, all from flip-flops
   assign bus_rdata_o = rdata_reg;
   assign bus_rvalid_o = rvalid_reg;
   assign scan_abort_o = (clr_reg == ibc_pkg::CLR_BUSY);
   assign mode_diff_o = mode_reg[0];
   assign mode_se_o = mode_reg[1];
   assign ref_ground_o = mode_reg[2];
   assign ref_vref_o = mode_reg[3];
   assign irq_o = g0_req_reg | g1_req_reg;

   // Checks
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   thr_write_a: assert property (
      wr_bctl |=> thr_reg == $past(bus_wdata_i[ibc_pkg::THR_LSB +: 16]))
      else $error("threshold not stored");
   clr_self_a: assert property (
      clr_start |=> scan_abort_o ##1 !scan_abort_o && count_reg == 16'h0000)
      else $error("clear did not finish in one cycle");
   clr_block_a: assert property (
      scan_abort_o |-> !sample_ready_o)
      else $error("samples accepted while clearing");
   tflag_read_a: assert property (
      hit(bus_rd_i, bus_addr_i, ibc_pkg::OFF_BUF_CTL) |=>
      bus_rdata_o[ibc_pkg::TFLAG_BIT] == ($past(count_reg) > $past(thr_reg))
      && bus_rdata_o[31:18] == 14'h0000)
      else $error("threshold flag wrong");
   fill_read_a: assert property (
      hit(bus_rd_i, bus_addr_i, ibc_pkg::OFF_FILL) |=>
      bus_rdata_o == {16'h0000, $past(count_reg)})
      else $error("fill count read wrong");
   data_upper_a: assert property (
      hit(bus_rd_i, bus_addr_i, ibc_pkg::OFF_DATA) |=>
      bus_rdata_o[31:16] == 16'h0000)
      else $error("data upper bits not zero");
   fn_ground_a: assert property (
      input_function_select_i == ibc_pkg::FN_ZERO |=>
      ref_ground_o && !mode_diff_o && !ref_vref_o)
      else $error("ground reference not selected");
   g0_done_a: assert property (
      g0_sel_reg == ibc_pkg::G0_SCAN_DONE && scan_done_i |=>
      g0_req_reg && irq_o)
      else $error("group 0 request not set");
   g0_idle_a: assert property (
      g0_sel_reg == ibc_pkg::G0_IDLE && !g0_req_reg && !wr_irq |=>
      !g0_req_reg)
      else $error("idle group 0 raised a request");
   g1_rise_a: assert property (
      g1_sel_reg == ibc_pkg::G1_RISE && $rose(tflag) |=> g1_req_reg)
      else $error("group 1 rise request missed");
   irq_clear_a: assert property (
      wr_irq && !bus_wdata_i[ibc_pkg::G1_REQ_BIT] &&
      !bus_wdata_i[ibc_pkg::G0_REQ_BIT] && !g0_ev && !g1_ev |=> !irq_o)
      else $error("interrupt stayed after clear");
   req_reset_a: assert property (
      $rose(rstn_i) |-> g0_req_reg && !g1_req_reg && irq_o)
      else $error("request reset values wrong");
   // Reserved condition codes must never raise a request
   g0_resv_a: assert property (
      g0_sel_reg > ibc_pkg::G0_SCAN_DONE && !g0_req_reg && !wr_irq |=>
      !g0_req_reg)
      else $error("reserved group 0 code raised a request");
   g1_resv_a: assert property (
      g1_sel_reg > ibc_pkg::G1_FALL && !g1_req_reg && !wr_irq |=>
      !g1_req_reg)
      else $error("reserved group 1 code raised a request");
   g1_fall_a: assert property (
      g1_sel_reg == ibc_pkg::G1_FALL && $fell(tflag) |=> g1_req_reg)
      else $error("group 1 fall request missed");
   fn_single_a: assert property (
      input_function_select_i == ibc_pkg::FN_SE |=>
      mode_se_o && !mode_diff_o && !ref_ground_o)
      else $error("single-ended mode not selected");
   fn_resv_a: assert property (
      input_function_select_i > ibc_pkg::FN_VREF |=>
      !mode_diff_o && !mode_se_o && !ref_ground_o && !ref_vref_o)
      else $error("reserved function code drove a mode line");
   fill_push_a: assert property (
      push && !pop && !scan_abort_o |=>
      count_reg == $past(count_reg) + 16'h0001)
      else $error("fill count missed a stored sample");

   clear_c: cover property (clr_start ##2 sample_ready_o);
   full_c: cover property (count_reg == DEPTH_C);
   g1_fall_c: cover property (g1_sel_reg == ibc_pkg::G1_FALL && g1_ev);
   pop_c: cover property (pop ##1 bus_rvalid_o);
endmodule : ibc_input_buffer

// ### logic/ibc_pkg.sv
// Shared constants for the input buffer and interrupt control block
package ibc_pkg;
   // Local bus register offsets (byte addresses)
   localparam logic [7:0] OFF_IRQ_CTL = 8'h04;
   localparam logic [7:0] OFF_DATA = 8'h08;
   localparam logic [7:0] OFF_BUF_CTL = 8'h0C;
   localparam logic [7:0] OFF_FILL = 8'h18;
   // Buffer control fields
   localparam int THR_LSB = 0;
   localparam int CLR_BIT = 16;
   localparam int TFLAG_BIT = 17;
   localparam logic [15:0] THR_RST = 16'hFFFE;
   // Interrupt control fields
   localparam int G0_SEL_LSB = 0;
   localparam int G0_REQ_BIT = 3;
   localparam int G1_SEL_LSB = 4;
   localparam int G1_REQ_BIT = 7;
   localparam logic [2:0] G0_SEL_RST = 3'h0;
   localparam logic G0_REQ_RST = 1'b1;
   localparam logic [2:0] G1_SEL_RST = 3'h0;
   localparam logic G1_REQ_RST = 1'b0;
   // Group 0 condition codes
   localparam logic [2:0] G0_IDLE = 3'h0;
   localparam logic [2:0] G0_AUTOCAL = 3'h1;
   localparam logic [2:0] G0_SCAN_START = 3'h2;
   localparam logic [2:0] G0_SCAN_DONE = 3'h3;
   // Group 1 condition codes
   localparam logic [2:0] G1_NONE = 3'h0;
   localparam logic [2:0] G1_RISE = 3'h1;
   localparam logic [2:0] G1_FALL = 3'h2;
   // Analog input function codes
   localparam logic [2:0] FN_DIFF = 3'h0;
   localparam logic [2:0] FN_SE = 3'h1;
   localparam logic [2:0] FN_ZERO = 3'h2;
   localparam logic [2:0] FN_VREF = 3'h3;
   // Clear sequencer states
   typedef enum logic {CLR_IDLE, CLR_BUSY} ibc_clr_type;
endpackage : ibc_pkg

// ### tb/ibc_sample_src.sv
`timescale 1ns/1ps
// Scan engine stand-in on the sample side of the buffer
module ibc_sample_src (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic en_i,
   input wire logic ready_i,
   input wire logic [15:0] data_i,
   output logic valid_o,
   output logic [15:0] data_o
);
   // Offer is held until taken; idle data toggles so nothing stale matches
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         valid_o <= 1'b0;
         data_o <= 16'h0000;
      end else if (!valid_o || ready_i) begin
         valid_o <= en_i;
         data_o <= en_i ? data_i : ~data_o;
      end
   end
endmodule : ibc_sample_src

// ### tb/ibc_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
   fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
   localparam int DEPTH = 8; // Small depth so full is reachable
   logic clk_sys_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic en = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic rvalid, sv, ready, abort, irq;
   logic [15:0] sd;
   logic [15:0] src_d = 16'h0000;
   logic [2:0] ev = 3'h0; // Autocal, scan start, scan done pulses
   logic [2:0] fsel = 3'h0;
   logic [3:0] mode;
   logic [31:0] seed = 32'h89E1E31A;
   logic [15:0] q[$]; // Samples the buffer accepted, oldest first
   logic [15:0] thr;
   logic [7:0] rc; // Reserved condition codes for both groups
   int fail_count = 0;
   int comparisons = 0;
   int cyc = 0;
   always #2 clk_sys_i = ~clk_sys_i;
   ibc_input_buffer #(.DEPTH(DEPTH)) dut_u (.clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i), .bus_addr_i(addr), .bus_wr_i(wr), .bus_rd_i(rd),
      .bus_wdata_i(wdata), .bus_rdata_o(rdata), .bus_rvalid_o(rvalid),
      .sample_valid_i(sv), .sample_data_i(sd), .sample_ready_o(ready),
      .autocal_done_i(ev[0]), .scan_start_i(ev[1]), .scan_done_i(ev[2]),
      .input_function_select_i(fsel), .scan_abort_o(abort),
      .mode_diff_o(mode[3]), .mode_se_o(mode[2]), .ref_ground_o(mode[1]),
      .ref_vref_o(mode[0]), .irq_o(irq));
   ibc_sample_src src_u (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .en_i(en), .ready_i(ready), .data_i(src_d), .valid_o(sv),
      .data_o(sd));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   // One-hot mode line per function code, none for reserved codes
   function automatic logic [3:0] mode_exp(input logic [2:0] f);
      return (f < 3'h4) ? (4'h8 >> f) : 4'h0;
   endfunction : mode_exp
   task automatic conclude;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude
   // Random sample data, accept monitor and hang guard
   always @(posedge clk_sys_i) begin
      cyc++;
      seed <= xs(seed);
      src_d <= seed[15:0];
      if (rstn_i && sv && ready) begin
         q.push_back(sd);
      end
      if (cyc == 20000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic bw(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
   endtask : bw
   // Answer is expected exactly one cycle after the strobe edge
   task automatic br(input logic [7:0] a, input logic [31:0] e,
      input string n);
      @(posedge clk_sys_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      @(negedge clk_sys_i);
      `CHK(n, {1'b1, e}, {rvalid, rdata})
   endtask : br
   task automatic pulse(input int i);
      @(posedge clk_sys_i);
      ev <= 3'h1 << i;
      @(posedge clk_sys_i);
      ev <= 3'h0;
   endtask : pulse
   initial begin
      repeat (2) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      br(ibc_pkg::OFF_IRQ_CTL, 32'h8, "irq_ctl");
      br(ibc_pkg::OFF_BUF_CTL, 32'hFFFE, "buf_ctl");
      br(ibc_pkg::OFF_FILL, 32'h0, "fill");
      `CHK("irq", 1'b1, irq)
      // Idle code: no event may raise group 0; upper bits ignored
      bw(ibc_pkg::OFF_IRQ_CTL, 32'hFFFF_FF00);
      for (int i = 0; i < 3; i++) pulse(i);
      br(ibc_pkg::OFF_IRQ_CTL, 32'h0, "g0_idle");
      `CHK("irq", 1'b0, irq)
      // Each code: a foreign event first, then its own
      for (int c = 1; c < 4; c++) begin
         bw(ibc_pkg::OFF_IRQ_CTL, 32'(c));
         pulse(c % 3);
         br(ibc_pkg::OFF_IRQ_CTL, 32'(c), "g0_other");
         pulse(c - 1);
         br(ibc_pkg::OFF_IRQ_CTL, 32'(c) | 32'h8, "g0_set");
      end
      for (int f = 0; f < 8; f++) begin
         @(posedge clk_sys_i);
         fsel <= 3'(f);
         @(posedge clk_sys_i);
         @(negedge clk_sys_i);
         `CHK("mode", mode_exp(3'(f)), mode)
      end
      // Fill to full while group 1 watches the rising flag
      thr = 16'(seed % 32'd5) + 16'h1;
      bw(ibc_pkg::OFF_IRQ_CTL, 32'h10);
      bw(ibc_pkg::OFF_BUF_CTL, 32'hFFFC_0000 | 32'(thr));
      br(ibc_pkg::OFF_BUF_CTL, 32'(thr), "thr");
      @(posedge clk_sys_i);
      en <= 1'b1;
      repeat (DEPTH + 4) @(posedge clk_sys_i);
      en <= 1'b0;
      br(ibc_pkg::OFF_FILL, 32'(DEPTH), "full");
      br(ibc_pkg::OFF_BUF_CTL, 32'h2_0000 | 32'(thr), "flag_hi");
      br(ibc_pkg::OFF_IRQ_CTL, 32'h90, "g1_rise");
      `CHK("irq", 1'b1, irq)
      // Drain three; the held offer slips in behind them
      repeat (3) br(ibc_pkg::OFF_DATA, {16'h0, q.pop_front()}, "data");
      repeat (2) @(posedge clk_sys_i);
      br(ibc_pkg::OFF_FILL, 32'(q.size()), "count");
      // Clear while above threshold; the flag falls and group 1 fires
      bw(ibc_pkg::OFF_IRQ_CTL, 32'h20);
      bw(ibc_pkg::OFF_BUF_CTL, 32'h1_0000 | 32'(thr));
      @(negedge clk_sys_i);
      `CHK("abort", 2'b10, {abort, ready})
      q.delete();
      br(ibc_pkg::OFF_BUF_CTL, 32'(thr), "clr_done");
      br(ibc_pkg::OFF_FILL, 32'h0, "emptied");
      br(ibc_pkg::OFF_IRQ_CTL, 32'hA0, "g1_fall");
      br(ibc_pkg::OFF_DATA, 32'h0, "empty_rd");
      bw(ibc_pkg::OFF_FILL, 32'hFFFF);
      br(ibc_pkg::OFF_FILL, 32'h0, "ro_fill");
      br(8'h40, 32'h0, "unmapped");
      // Reserved codes in both groups: events and a flag rise stay silent
      rc = {1'b0, 3'(seed % 32'd5 + 32'd3), 1'b0, 1'b1, seed[9:8]};
      bw(ibc_pkg::OFF_IRQ_CTL, {24'h00_0000, rc});
      for (int i = 0; i < 3; i++) pulse(i);
      @(posedge clk_sys_i);
      en <= 1'b1;
      repeat (DEPTH + 4) @(posedge clk_sys_i);
      en <= 1'b0;
      br(ibc_pkg::OFF_IRQ_CTL, {24'h00_0000, rc}, "resv");
      `CHK("irq", 1'b0, irq)
      // Mid-run reset must restore every register, held offer dropped
      @(posedge clk_sys_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      br(ibc_pkg::OFF_BUF_CTL, 32'hFFFE, "rst_thr");
      br(ibc_pkg::OFF_FILL, 32'h0, "rst_fill");
      br(ibc_pkg::OFF_IRQ_CTL, 32'h8, "rst_irq");
      `CHK("irq", 1'b1, irq)
      conclude();
   end
endmodule : testbench
